// File: rtl/boot_map.svh
// Constants for the reset configuration and boot selection pair.
// Assumes inclusion by bare name from both ends of the link.
`ifndef BOOT_MAP_SVH
`define BOOT_MAP_SVH

// Boot mode pin codes
`define BOOT_CODE_HOST_PLL_OFF 2'h0
`define BOOT_CODE_SERIAL       2'h1
`define BOOT_CODE_HOST_PLL_ON  2'h2
`define BOOT_CODE_RESERVED     2'h3

// Boot loader run time from internal ROM, in ref_clk cycles
`define ROM_LOAD_CYCLES        8'h10

// Host port sizes and buffering
`define HOST_WORD_BITS         16
`define GROUP_WORDS            4
`define FIFO_DEPTH_WORDS       8

// Host end register offsets (byte addresses)
`define REG_CTRL_OFF           32'h0000_0000
`define REG_DATA_OFF           32'h0000_0004
`define REG_STAT_OFF           32'h0000_0008

// Control register fields
`define CTRL_POR_BIT           0
`define CTRL_HRST_BIT          1
`define CTRL_MODE_LSB          2
`define CTRL_WIDTH8_BIT        4
`define CTRL_STROBE_A_BIT      5
`define CTRL_STROBE_B_BIT      6
`define CTRL_REQ_STRAP_BIT     7
`define CTRL_RESET_VAL         8'h01

// Status register fields
`define STAT_BUSY_BIT          0
`define STAT_DEV_READY_BIT     1
`define STAT_HRST_LEVEL_BIT    2
`define STAT_POR_LEVEL_BIT     3

// Guard cycles after each host port write before ready is trusted
`define HOST_WRITE_GAP         2'h2

`endif

// File: rtl/boot_pkg.sv
// Types used by the boot device end of the link and by the testbench.
// Assumes boot_map.svh supplies the numeric constants.
package boot_pkg;

    typedef enum logic [2:0] {
        ST_POR_HOLD,
        ST_HARD_HOLD,
        ST_ROM_INIT,
        ST_HOST_BOOT,
        ST_SERIAL_BOOT,
        ST_RESERVED,
        ST_RUN
    } dev_state_type;

    typedef enum logic [1:0] {
        SRC_HOST_PLL_OFF,
        SRC_SERIAL,
        SRC_HOST_PLL_ON,
        SRC_RESERVED
    } boot_src_type;

endpackage

// File: rtl/boot_link_if.sv
// Pins between the boot device and the external host.
// Assumes both ends share ref_clk; open-drain levels resolved here.
`timescale 1ns/1ps
`default_nettype none

interface boot_link_if;
    logic        por_n;
    logic [1:0]  boot_mode_pins;
    logic        host_width_select;
    logic        host_strobe_cfg_a;
    logic        host_strobe_cfg_b;
    logic        hrst_dev_o;
    logic        hrst_dev_oe;
    logic        hrst_host_o;
    logic        hrst_host_oe;
    logic        hard_reset_line;
    logic        req_dev_o;
    logic        req_dev_oe;
    logic        req_strap;
    logic        host_request_pin;
    logic [15:0] host_data;
    logic        host_write;

    // Pulled up; any enabled driver pulls low
    assign hard_reset_line = !((hrst_dev_oe && !hrst_dev_o) ||
                               (hrst_host_oe && !hrst_host_o));
    assign host_request_pin = req_dev_oe ? req_dev_o : req_strap;

    modport dev (
        input  por_n, boot_mode_pins, host_width_select,
        input  host_strobe_cfg_a, host_strobe_cfg_b,
        input  hard_reset_line, host_request_pin, host_data, host_write,
        output hrst_dev_o, hrst_dev_oe, req_dev_o, req_dev_oe
    );

    modport host (
        output por_n, boot_mode_pins, host_width_select,
        output host_strobe_cfg_a, host_strobe_cfg_b,
        output hrst_host_o, hrst_host_oe, req_strap, host_data, host_write,
        input  hard_reset_line, host_request_pin
    );
endinterface

`default_nettype wire

// File: rtl/boot_fifo.sv
// Word FIFO in the host port data path of the boot device.
// Assumes one clock; push and pop use valid/ready handshakes.
`timescale 1ns/1ps
`default_nettype none

module boot_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    wire              push;
    wire              pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ?
                            '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ?
                            '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

`default_nettype wire

// File: rtl/reset_config_boot_select.sv
// Boot device end: captures reset straps, picks the boot source and
// runs the host port or serial boot setup.
// Assumes link pins synchronous to ref_clk; host honours ready polling.
//
// The register offsets and register access over APB are this design's own decisions.
`include "boot_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Latch all straps at power-on reset release
// - PLL bypassed after power-on reset until enabled
// - Run ROM loader first; core may enable PLL
// - Boot source from mode pins at release
// - Four outcomes: host PLL off, serial, host PLL on, reserved
// - Host boot: no DMA, polling on both sides
// - Host writes four words, most significant first
// - Width select pin picks 8 or 16 bits
// - Two strobe pins set the data strobe scheme
// - Host straps only at power-on; hard reset keeps them
// - Host data bit zero is least significant
// - Serial boot: pins to serial, device is master
// - Hard reset line is open-drain, bidirectional
// - Host request pin sampled during power-on reset
module reset_config_boot_select (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    boot_link_if.dev                   link,
    input  wire logic                  pll_enable_req,
    input  wire logic                  hard_reset_req,
    input  wire logic                  boot_finish,
    output logic                       pll_bypass,
    output boot_pkg::boot_src_type     boot_source,
    output logic                       boot_busy,
    output logic                       boot_error,
    output logic                       cfg_width_8,
    output logic [1:0]                 cfg_strobe,
    output logic                       cfg_host_req,
    output logic                       host_dma_en,
    output logic                       host_irq_en,
    output logic                       serial_pins_sel,
    output logic                       serial_master_en,
    output logic [63:0]                boot_word,
    output logic                       boot_word_valid,
    input  wire logic                  boot_word_ready
);
    boot_pkg::dev_state_type state_r;
    boot_pkg::dev_state_type state_nxt;
    boot_pkg::boot_src_type  src_r;

    logic        por_q_r;
    logic [7:0]  rom_cnt_r;
    logic        pll_bypass_r;
    logic        width_8_r;
    logic [1:0]  strobe_r;
    logic        host_req_r;
    logic        err_r;
    logic        ser_r;
    logic        req_o_r;
    logic        hrst_oe_r;
    logic        byte_hi_r;
    logic [7:0]  byte_lo_r;
    logic [1:0]  grp_cnt_r;
    logic [63:0] grp_r;
    logic        grp_valid_r;
    logic        busy_r;

    wire         por_rise;
    wire         in_host;
    wire         link_write;
    wire         word_done;
    wire [15:0]  word_in;
    wire         fifo_in_ready;
    wire [15:0]  fifo_out_data;
    wire         fifo_out_valid;
    wire         fifo_pop;
    wire         grp_take;

    // Release edge of power-on reset, seen in the first cycle that por_n reads high
    assign por_rise = link.por_n && !por_q_r;
    assign in_host  = (state_r == boot_pkg::ST_HOST_BOOT);
    assign link_write = in_host && link.host_write;
    // 8-bit mode pairs bytes low then high; bit 0 stays the LSB
    assign word_done = link_write && (!width_8_r || byte_hi_r);
    assign word_in = width_8_r ? {link.host_data[7:0], byte_lo_r}
                               : link.host_data;
    assign fifo_pop = fifo_out_valid && !grp_valid_r;
    assign grp_take = grp_valid_r && boot_word_ready;

    boot_fifo #(
        .WIDTH (`HOST_WORD_BITS),
        .DEPTH (`FIFO_DEPTH_WORDS)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_data   (word_in),
        .in_valid  (word_done),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            boot_pkg::ST_POR_HOLD: begin
                if (por_rise) begin
                    state_nxt = boot_pkg::ST_ROM_INIT;
                end
            end
            boot_pkg::ST_HARD_HOLD: begin
                if (link.hard_reset_line && !hrst_oe_r) begin
                    state_nxt = boot_pkg::ST_ROM_INIT;
                end
            end
            boot_pkg::ST_ROM_INIT: begin
                if (rom_cnt_r == `ROM_LOAD_CYCLES) begin
                    case (src_r)
                        boot_pkg::SRC_SERIAL:
                            state_nxt = boot_pkg::ST_SERIAL_BOOT;
                        boot_pkg::SRC_RESERVED:
                            state_nxt = boot_pkg::ST_RESERVED;
                        default:
                            state_nxt = boot_pkg::ST_HOST_BOOT;
                    endcase
                end
            end
            boot_pkg::ST_HOST_BOOT, boot_pkg::ST_SERIAL_BOOT: begin
                if (boot_finish) begin
                    state_nxt = boot_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = state_r;
            end
        endcase
        // Hard reset reboots without touching captured straps
        if (!link.hard_reset_line || hrst_oe_r) begin
            state_nxt = boot_pkg::ST_HARD_HOLD;
        end
        if (!link.por_n) begin
            state_nxt = boot_pkg::ST_POR_HOLD;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r   <= boot_pkg::ST_POR_HOLD;
            por_q_r   <= 1'b0;
            rom_cnt_r <= 8'h00;
            busy_r    <= 1'b1;
        end else if (ce) begin
            state_r   <= state_nxt;
            busy_r    <= (state_nxt != boot_pkg::ST_RUN);
            por_q_r   <= link.por_n;
            rom_cnt_r <= (state_nxt == boot_pkg::ST_ROM_INIT &&
                          state_r == boot_pkg::ST_ROM_INIT) ?
                         rom_cnt_r + 8'h01 : 8'h00;
        end
    end

    // Strap capture only at power-on release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            src_r      <= boot_pkg::SRC_HOST_PLL_OFF;
            width_8_r  <= 1'b0;
            strobe_r   <= 2'h0;
            host_req_r <= 1'b0;
        end else if (ce && por_rise) begin
            src_r      <= boot_pkg::boot_src_type'(
                              link.boot_mode_pins);
            width_8_r  <= link.host_width_select;
            strobe_r   <= {link.host_strobe_cfg_b,
                           link.host_strobe_cfg_a};
            host_req_r <= link.host_request_pin;
        end
    end

    // PLL stays bypassed from power-on until core or mode enables it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pll_bypass_r <= 1'b1;
        end else if (ce) begin
            if (!link.por_n) begin
                pll_bypass_r <= 1'b1;
            end else if (pll_enable_req &&
                         state_r != boot_pkg::ST_POR_HOLD) begin
                pll_bypass_r <= 1'b0;
            end else if (state_r == boot_pkg::ST_ROM_INIT &&
                         state_nxt == boot_pkg::ST_HOST_BOOT &&
                         src_r == boot_pkg::SRC_HOST_PLL_ON) begin
                pll_bypass_r <= 1'b0;
            end
        end
    end

    // Ready drops for a cycle after each write so the host re-polls
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_o_r   <= 1'b0;
            byte_hi_r <= 1'b0;
            byte_lo_r <= 8'h00;
            err_r     <= 1'b0;
            ser_r     <= 1'b0;
            hrst_oe_r <= 1'b0;
        end else if (ce) begin
            req_o_r   <= (state_nxt == boot_pkg::ST_HOST_BOOT) &&
                         fifo_in_ready && !link.host_write;
            hrst_oe_r <= hard_reset_req;
            err_r     <= (state_nxt == boot_pkg::ST_RESERVED);
            ser_r     <= (state_nxt == boot_pkg::ST_SERIAL_BOOT);
            if (!in_host) begin
                byte_hi_r <= 1'b0;
            end else if (link_write && width_8_r) begin
                byte_hi_r <= !byte_hi_r;
                byte_lo_r <= link.host_data[7:0];
            end
        end
    end

    // Group four words, first one lands in the top bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            grp_cnt_r   <= 2'h0;
            grp_r       <= 64'h0000_0000_0000_0000;
            grp_valid_r <= 1'b0;
        end else if (ce) begin
            if (grp_take) begin
                grp_valid_r <= 1'b0;
            end else if (fifo_pop) begin
                grp_r       <= {grp_r[47:0], fifo_out_data};
                grp_cnt_r   <= grp_cnt_r + 2'h1;
                grp_valid_r <= (grp_cnt_r == 2'(`GROUP_WORDS - 1));
            end
        end
    end

    assign link.req_dev_o   = req_o_r;
    assign link.req_dev_oe  = !(state_r == boot_pkg::ST_POR_HOLD);
    assign link.hrst_dev_o  = 1'b0;
    assign link.hrst_dev_oe = hrst_oe_r;

    assign pll_bypass       = pll_bypass_r;
    assign boot_source      = src_r;
    assign boot_busy        = busy_r;
    assign boot_error       = err_r;
    assign cfg_width_8      = width_8_r;
    assign cfg_strobe       = strobe_r;
    assign cfg_host_req     = host_req_r;
    assign host_dma_en      = 1'b0;
    assign host_irq_en      = 1'b0;
    assign serial_pins_sel  = ser_r;
    assign serial_master_en = ser_r;
    assign boot_word        = grp_r;
    assign boot_word_valid  = grp_valid_r;
endmodule

`default_nettype wire

// File: rtl/boot_host_end.sv
// External host end: straps, power-on and hard reset control and
// polled boot word writes, ordered by software over APB.
// Assumes APB shares ref_clk; device drives ready on the request pin.
`include "boot_map.svh"
`timescale 1ns/1ps
`default_nettype none

module boot_host_end (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    boot_link_if.host        link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    logic [7:0]  ctrl_r;
    logic [15:0] word_r;
    logic        pending_r;
    logic        byte_hi_r;
    logic [1:0]  gap_r;
    logic [15:0] data_o_r;
    logic        write_o_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    wire         hit_ctrl;
    wire         hit_data;
    wire         hit_stat;
    wire         access;
    wire         accept;
    wire         done;
    wire         send;
    wire         last_piece;
    wire [31:0]  stat_val;

    assign hit_ctrl = (paddr == `REG_CTRL_OFF);
    assign hit_data = (paddr == `REG_DATA_OFF);
    assign hit_stat = (paddr == `REG_STAT_OFF);
    assign access   = ce && psel && penable;
    // Data writes wait while the previous word is still going out
    assign accept   = access && !pready_r &&
                      !(hit_data && pwrite && pending_r);
    assign done     = access && pready_r;
    // Polled only: write once ready is seen and the guard has passed
    assign send       = ce && pending_r && gap_r == 2'h0 &&
                        link.host_request_pin;
    assign last_piece = !ctrl_r[`CTRL_WIDTH8_BIT] || byte_hi_r;
    assign stat_val   = {28'h000_0000, link.por_n, link.hard_reset_line,
                         link.host_request_pin, pending_r};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (ce) begin
            pready_r  <= accept;
            pslverr_r <= accept && !(hit_ctrl || hit_data || hit_stat);
            prdata_r  <= !accept ? 32'h0000_0000 :
                         hit_ctrl ? {24'h00_0000, ctrl_r} :
                         hit_stat ? stat_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r    <= `CTRL_RESET_VAL;
            word_r    <= 16'h0000;
            pending_r <= 1'b0;
            byte_hi_r <= 1'b0;
            gap_r     <= 2'h0;
            data_o_r  <= 16'h0000;
            write_o_r <= 1'b0;
        end else if (ce) begin
            write_o_r <= send;
            if (gap_r != 2'h0) begin
                gap_r <= gap_r - 2'h1;
            end
            if (send) begin
                gap_r     <= `HOST_WRITE_GAP;
                data_o_r  <= (ctrl_r[`CTRL_WIDTH8_BIT] && byte_hi_r) ?
                             {8'h00, word_r[15:8]} :
                             ctrl_r[`CTRL_WIDTH8_BIT] ?
                             {8'h00, word_r[7:0]} : word_r;
                byte_hi_r <= !last_piece;
                pending_r <= !last_piece;
            end
            if (done && pwrite && hit_ctrl) begin
                ctrl_r <= pwdata[7:0];
            end
            if (done && pwrite && hit_data) begin
                word_r    <= pwdata[15:0];
                pending_r <= 1'b1;
                byte_hi_r <= 1'b0;
            end
        end
    end

    assign link.por_n             = !ctrl_r[`CTRL_POR_BIT];
    assign link.boot_mode_pins    = ctrl_r[`CTRL_MODE_LSB +: 2];
    assign link.host_width_select = ctrl_r[`CTRL_WIDTH8_BIT];
    assign link.host_strobe_cfg_a = ctrl_r[`CTRL_STROBE_A_BIT];
    assign link.host_strobe_cfg_b = ctrl_r[`CTRL_STROBE_B_BIT];
    assign link.req_strap         = ctrl_r[`CTRL_REQ_STRAP_BIT];
    // Open-drain: only ever pulls low
    assign link.hrst_host_o       = 1'b0;
    assign link.hrst_host_oe      = ctrl_r[`CTRL_HRST_BIT];
    assign link.host_data         = data_o_r;
    assign link.host_write        = write_o_r;
    assign prdata                 = prdata_r;
    assign pready                 = pready_r;
    assign pslverr                = pslverr_r;
endmodule

`default_nettype wire

// File: testbench/boot_link_chk.sv
// Checker on the pins between the boot device and the host end.
// Assumes one clock, ref_clk, and reset rst_n, synchronous, active low.
`timescale 1ns/1ps
`default_nettype none

module boot_link_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic hrst_dev_o,
    input wire logic hrst_dev_oe,
    input wire logic hrst_host_o,
    input wire logic hrst_host_oe,
    input wire logic req_dev_oe,
    input wire logic host_request_pin,
    input wire logic host_write
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_dev_od; hrst_dev_oe |-> !hrst_dev_o; endproperty
    a_dev_od: assert property (p_dev_od)
        else $error("device drives hard reset high");
    property p_host_od; hrst_host_oe |-> !hrst_host_o; endproperty
    a_host_od: assert property (p_host_od)
        else $error("host drives hard reset high");
    property p_oe_hold; !por_n [*3] |-> !req_dev_oe; endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("request pin driven during power-on hold");
    property p_oe_release; $rose(por_n) |-> ##[1:3] req_dev_oe; endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("request pin not taken over after release");
    property p_rom_quiet;
        $rose(por_n) |-> ##3 (!host_request_pin) [*8];
    endproperty
    a_rom_quiet: assert property (p_rom_quiet)
        else $error("ready shown while loader runs");
    property p_write_ready; host_write |-> host_request_pin; endproperty
    a_write_ready: assert property (p_write_ready)
        else $error("host wrote without ready");
    property p_req_fall; host_write |=> !host_request_pin; endproperty
    a_req_fall: assert property (p_req_fall)
        else $error("ready stayed up after a write");
    property p_write_gap; host_write |=> (!host_write) [*2]; endproperty
    a_write_gap: assert property (p_write_gap)
        else $error("host writes too close together");
endmodule

`default_nettype wire

// File: testbench/testbench.sv
// Bench joining the boot device and the host end over the link.
// Assumes APB on ref_clk at 40 MHz; straps set through host CTRL.
`include "boot_map.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                   ref_clk, rst_n, psel, penable, pwrite, e;
    logic [31:0]            paddr, pwdata, prdata, r;
    logic                   pready, pslverr, boot_word_valid;
    logic                   pll_enable_req, hard_reset_req, boot_finish;
    logic                   boot_word_ready, pll_bypass, boot_busy;
    logic                   boot_error, cfg_width_8, cfg_host_req;
    logic                   host_dma_en, host_irq_en;
    logic                   serial_pins_sel, serial_master_en;
    logic [1:0]             cfg_strobe, m;
    logic [3:0]             s;
    logic [63:0]            boot_word;
    logic [63:0]            exp_w [3];
    boot_pkg::boot_src_type boot_source;
    int                     errors, check_count;

    boot_link_if link ();
    reset_config_boot_select i_reset_config_boot_select (.ref_clk, .rst_n,
        .ce(1'h1), .link(link), .pll_enable_req, .hard_reset_req,
        .boot_finish, .pll_bypass, .boot_source, .boot_busy, .boot_error,
        .cfg_width_8, .cfg_strobe, .cfg_host_req, .host_dma_en,
        .host_irq_en, .serial_pins_sel, .serial_master_en, .boot_word,
        .boot_word_valid, .boot_word_ready);
    boot_host_end i_boot_host_end (.ref_clk, .rst_n, .ce(1'h1),
        .link(link), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    boot_link_chk i_boot_link_chk (.ref_clk, .rst_n, .por_n(link.por_n),
        .hrst_dev_o(link.hrst_dev_o), .hrst_dev_oe(link.hrst_dev_oe),
        .hrst_host_o(link.hrst_host_o), .hrst_host_oe(link.hrst_host_oe),
        .req_dev_oe(link.req_dev_oe), .host_write(link.host_write),
        .host_request_pin(link.host_request_pin));

    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Straps {req, b, a, width8}, then mode, hard reset, power-on
    function automatic logic [31:0] ctrl_val(input logic [1:0] md,
        input logic [3:0] st, input logic h, input logic p);
        return {24'h0, st, md, h, p};
    endfunction

    task automatic chk(input string n, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge ref_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wait_edges(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Three groups queued while the consumer stalls, so the FIFO fills
    task automatic push_words;
        logic [15:0] w;
        for (int g = 0; g < 3; g++) begin
            for (int k = 0; k < 4; k++) begin
                w = 16'($urandom);
                exp_w[g] = {exp_w[g][47:0], w};
                apb(1'h1, `REG_DATA_OFF, {16'h0, w});
            end
        end
        for (int g = 0; g < 3; g++) begin
            for (int k = 0; k < 40 && boot_word_valid !== 1'h1; k++)
                @(posedge ref_clk);
            chk("valid", boot_word_valid, 1'h1);
            chk("boot_word", boot_word, exp_w[g]);
            boot_word_ready <= 1'h1;
            @(posedge ref_clk);
            boot_word_ready <= 1'h0;
            wait_edges(3);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        wait_edges(30000);
        errors++;
        stop_test();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pll_enable_req, hard_reset_req, boot_finish} = '0;
        boot_word_ready = 1'h0;
        rst_n = 1'h0;
        errors = 0;
        check_count = 0;
        void'($urandom(32'h3BC4));
        wait_edges(8);
        rst_n <= 1'h1;
        apb(1'h0, `REG_CTRL_OFF, 32'h0);
        chk("ctrl", {pll_bypass, r[7:0]}, {1'h1, `CTRL_RESET_VAL});
        apb(1'h0, 32'h0000_0010, 32'h0);
        chk("unmapped", {e, r}, {1'h1, 32'h0});
        for (int i = 0; i < 8; i++) begin
            m = i[1:0];
            s = 4'($urandom);
            // Upper half of the loop straps the host port for 8-bit mode
            s[0] = i[2];
            apb(1'h1, `REG_CTRL_OFF, ctrl_val(m, s, 1'h0, 1'h1));
            apb(1'h1, `REG_CTRL_OFF, ctrl_val(m, s, 1'h0, 1'h0));
            wait_edges(30);
            chk("source", boot_source, m);
            chk("straps", {cfg_host_req, cfg_strobe, cfg_width_8},
                s);
            chk("bypass", pll_bypass, m != 2'h2);
            chk("error", boot_error, m == 2'h3);
            chk("serial", {serial_pins_sel, serial_master_en},
                {2{m == 2'h1}});
            chk("poll", {host_dma_en, host_irq_en, boot_busy},
                3'h1);
            if (!m[0])
                push_words();
            apb(1'h1, `REG_CTRL_OFF, ctrl_val(~m, ~s, 1'h1, 1'h0));
            apb(1'h0, `REG_STAT_OFF, 32'h0);
            chk("hrst_line", {r[3], r[2]}, 2'h2);
            apb(1'h1, `REG_CTRL_OFF, ctrl_val(~m, ~s, 1'h0, 1'h0));
            wait_edges(30);
            chk("kept", {boot_source, cfg_host_req, cfg_strobe, cfg_width_8},
                {m, s});
            if (m != 2'h3) begin
                boot_finish <= 1'h1;
                @(posedge ref_clk);
                boot_finish <= 1'h0;
                wait_edges(3);
                chk("run", {boot_busy, pll_bypass},
                    {1'h0, m != 2'h2});
                pll_enable_req <= 1'h1;
                wait_edges(3);
                chk("pll_on", pll_bypass, 1'h0);
                pll_enable_req <= 1'h0;
                hard_reset_req <= 1'h1;
                wait_edges(3);
                apb(1'h0, `REG_STAT_OFF, 32'h0);
                chk("dev_hrst", r[2], 1'h0);
                hard_reset_req <= 1'h0;
                wait_edges(30);
            end
        end
        stop_test();
    end
endmodule

`default_nettype wire
